/* rtl/dprb_bank.v */
`include "dprb_map.vh"
`timescale 1ns/100ps
`default_nettype none
module dprb_bank (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        wr_en,
  input  wire        rd_en,
  input  wire [15:0] addr,
  input  wire [15:0] wdata,
  output reg  [15:0] rdata,
  output reg         ack,
  output reg         nack,
  input  wire        run_state,
  input  wire        ramping_phase,
  output wire [1:0]  control_strategy,
  output wire        current_limit_active,
  output wire [15:0] current_limit_level,
  output wire        dynamic_brake_active,
  output wire        dc_brake_enable,
  output wire [15:0] dc_brake_level,
  output wire [15:0] dc_brake_start_freq,
  output wire [15:0] dc_brake_time,
  output wire [15:0] start_freq,
  output wire [15:0] start_freq_hold_time,
  output wire [15:0] stop_freq,
  output wire [15:0] stop_freq_hold_time,
  output wire [15:0] carrier_freq,
  output wire [15:0] freq_limit_low,
  output wire [15:0] freq_limit_high,
  output wire [15:0] arrival_hysteresis,
  output wire [15:0] detect_level,
  output wire [15:0] detect_hysteresis,
  output wire [15:0] speed_display_coeff,
  output wire [15:0] brake_release_current,
  output wire [15:0] brake_release_freq,
  output wire [15:0] brake_release_timer,
  output wire [16*7-1:0] terminal_functions
);

  localparam NREG = 31;

  // index of a word address, NREG when unmapped
  function [4:0] reg_index;
    input [15:0] a;
    begin
      case (a)
        `DPRB_A_FLIM_LOW:   reg_index = 5'h00;
        `DPRB_A_DCB_FREQ:   reg_index = 5'h01;
        `DPRB_A_DCB_LEVEL:  reg_index = 5'h02;
        `DPRB_A_DCB_TIME:   reg_index = 5'h03;
        `DPRB_A_START_FREQ: reg_index = 5'h04;
        `DPRB_A_START_HOLD: reg_index = 5'h05;
        `DPRB_A_STOP_FREQ:  reg_index = 5'h06;
        `DPRB_A_CARRIER:    reg_index = 5'h07;
        `DPRB_A_STOP_HOLD:  reg_index = 5'h08;
        `DPRB_A_CTRL_STRAT: reg_index = 5'h09;
        `DPRB_A_CLIM_MODE:  reg_index = 5'h0a;
        `DPRB_A_CLIM_LEVEL: reg_index = 5'h0b;
        `DPRB_A_BR_DUTY:    reg_index = 5'h0c;
        `DPRB_A_DIG_FREF:   reg_index = 5'h0d;
        `DPRB_A_TQ_BOOST:   reg_index = 5'h0e;
        `DPRB_A_DYN_BRAKE:  reg_index = 5'h0f;
        `DPRB_A_IN1_FUNC:   reg_index = 5'h10;
        `DPRB_A_IN2_FUNC:   reg_index = 5'h11;
        `DPRB_A_IN3_FUNC:   reg_index = 5'h12;
        `DPRB_A_IN4_FUNC:   reg_index = 5'h13;
        `DPRB_A_IN5_FUNC:   reg_index = 5'h14;
        `DPRB_A_TOUT_FUNC:  reg_index = 5'h15;
        `DPRB_A_ROUT_FUNC:  reg_index = 5'h16;
        `DPRB_A_ARR_HYST:   reg_index = 5'h17;
        `DPRB_A_DET_LEVEL:  reg_index = 5'h18;
        `DPRB_A_DET_HYST:   reg_index = 5'h19;
        `DPRB_A_SPD_COEFF:  reg_index = 5'h1a;
        `DPRB_A_BRK_CUR:    reg_index = 5'h1b;
        `DPRB_A_BRK_FREQ:   reg_index = 5'h1c;
        `DPRB_A_BRK_TIMER:  reg_index = 5'h1d;
        `DPRB_A_FLIM_HIGH:  reg_index = 5'h1e;
        default:            reg_index = 5'h1f;
      endcase
    end
  endfunction

  function [15:0] reset_value;
    input [4:0] i;
    begin
      case (i)
        5'h00:   reset_value = `DPRB_R_FLIM_LOW;
        5'h01:   reset_value = `DPRB_R_DCB_FREQ;
        5'h02:   reset_value = `DPRB_R_DCB_LEVEL;
        5'h03:   reset_value = `DPRB_R_DCB_TIME;
        5'h04:   reset_value = `DPRB_R_START_FREQ;
        5'h05:   reset_value = `DPRB_R_START_HOLD;
        5'h06:   reset_value = `DPRB_R_STOP_FREQ;
        5'h07:   reset_value = `DPRB_R_CARRIER;
        5'h08:   reset_value = `DPRB_R_STOP_HOLD;
        5'h09:   reset_value = `DPRB_R_CTRL_STRAT;
        5'h0a:   reset_value = `DPRB_R_CLIM_MODE;
        5'h0b:   reset_value = `DPRB_R_CLIM_LEVEL;
        5'h0c:   reset_value = `DPRB_R_BR_DUTY;
        5'h0d:   reset_value = `DPRB_R_DIG_FREF;
        5'h0e:   reset_value = `DPRB_R_TQ_BOOST;
        5'h0f:   reset_value = `DPRB_R_DYN_BRAKE;
        5'h10:   reset_value = `DPRB_R_IN1_FUNC;
        5'h11:   reset_value = `DPRB_R_IN2_FUNC;
        5'h12:   reset_value = `DPRB_R_IN3_FUNC;
        5'h13:   reset_value = `DPRB_R_IN4_FUNC;
        5'h14:   reset_value = `DPRB_R_IN5_FUNC;
        5'h15:   reset_value = `DPRB_R_TOUT_FUNC;
        5'h16:   reset_value = `DPRB_R_ROUT_FUNC;
        5'h17:   reset_value = `DPRB_R_ARR_HYST;
        5'h18:   reset_value = `DPRB_R_DET_LEVEL;
        5'h19:   reset_value = `DPRB_R_DET_HYST;
        5'h1a:   reset_value = `DPRB_R_SPD_COEFF;
        5'h1b:   reset_value = `DPRB_R_BRK_CUR;
        5'h1c:   reset_value = `DPRB_R_BRK_FREQ;
        5'h1d:   reset_value = `DPRB_R_BRK_TIMER;
        5'h1e:   reset_value = `DPRB_R_FLIM_HIGH;
        default: reset_value = 16'h0000;
      endcase
    end
  endfunction

  function in_range;
    input [15:0] v;
    input [15:0] lo;
    input [15:0] hi;
    begin
      in_range = (v >= lo) && (v <= hi);
    end
  endfunction

  // range check per field except the function fields; inverted run codes are refused on inputs, output codes take any value
  function accept;
    input [4:0]  i;
    input [15:0] v;
    begin
      case (i)
        5'h00, 5'h1e: accept = in_range(v, 16'h0000, `DPRB_MAX_FREQ120);
        5'h01: accept = in_range(v, 16'h0000, `DPRB_MAX_FREQ60);
        5'h02: accept = in_range(v, 16'h0000, `DPRB_MAX_PCT100);
        5'h03: accept = in_range(v, 16'h0000, `DPRB_MAX_DCB_TIME);
        5'h04: accept = in_range(v, `DPRB_MIN_FREQ01, `DPRB_MAX_FREQ60);
        5'h05: accept = in_range(v, 16'h0000, `DPRB_MAX_HOLD);
        5'h06: accept = in_range(v, `DPRB_MIN_FREQ01, `DPRB_MAX_FREQ60);
        5'h07: accept = in_range(v, `DPRB_MIN_CARRIER, `DPRB_MAX_CARRIER);
        5'h08: accept = in_range(v, 16'h0000, `DPRB_MAX_HOLD);
        5'h09, 5'h0a, 5'h0f: accept = in_range(v, 16'h0000, `DPRB_MAX_MODE2);
        5'h0b: accept = in_range(v, `DPRB_MIN_PCT20, `DPRB_MAX_PCT200);
        5'h0c: accept = in_range(v, `DPRB_MIN_DUTY, `DPRB_MAX_DUTY);
        5'h0d: accept = in_range(v, 16'h0000, `DPRB_MAX_FREF);
        5'h0e: accept = in_range(v, 16'h0000, `DPRB_MAX_BOOST);
        5'h10, 5'h11, 5'h12, 5'h13, 5'h14:
          accept = (v != `DPRB_FUNC_INV_FWD) && (v != `DPRB_FUNC_INV_REV);
        5'h15, 5'h16: accept = 1'b1;
        5'h17: accept = in_range(v, 16'h0000, `DPRB_MAX_ARR_HYST);
        5'h18, 5'h19: accept = in_range(v, 16'h0000, `DPRB_MAX_FREQ120);
        5'h1a: accept = in_range(v, `DPRB_MIN_COEFF, `DPRB_MAX_COEFF);
        5'h1b: accept = in_range(v, 16'h0000, `DPRB_MAX_PCT200);
        5'h1c: accept = in_range(v, 16'h0000, `DPRB_MAX_FREQ25);
        5'h1d: accept = in_range(v, 16'h0000, `DPRB_MAX_TIMER5);
        default: accept = 1'b0;
      endcase
    end
  endfunction

  reg  [15:0] regs_r [0:NREG-1];
  wire [4:0]  idx    = reg_index(addr);
  wire        mapped = (idx != 5'h1f);
  wire        wr_ok  = wr_en && mapped && accept(idx, wdata);

  genvar g;
  generate
    for (g = 0; g < NREG; g = g + 1) begin : g_reg
      // index and default fixed per slot so the reset branch loads a plain constant
      localparam [4:0]  GI    = g;
      localparam [15:0] RST_V = reset_value(GI);
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          regs_r[g] <= RST_V;
        end else if (wr_ok && (idx == GI)) begin
          regs_r[g] <= wdata;
        end
      end
    end
  endgenerate

  // one-cycle answer; writes out of range or unmapped answer nack
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 16'h0000;
      ack   <= 1'b0;
      nack  <= 1'b0;
    end else begin
      ack   <= wr_ok || (rd_en && !wr_en && mapped);
      nack  <= (wr_en && !wr_ok) || (rd_en && !wr_en && !mapped);
      if (rd_en && !wr_en) begin
        rdata <= mapped ? regs_r[idx] : 16'h0000;
      end
    end
  end

  assign control_strategy = regs_r[9][1:0];

  assign current_limit_active = (regs_r[10] == 16'h0002) ||
                                ((regs_r[10] == 16'h0001) && run_state && !ramping_phase);
  assign current_limit_level  = regs_r[11];

  assign dynamic_brake_active = (regs_r[15] == 16'h0002) ||
                                ((regs_r[15] == 16'h0001) && run_state);

  assign dc_brake_enable      = (regs_r[3] != 16'h0000);

  assign freq_limit_low        = regs_r[0];
  assign dc_brake_start_freq   = regs_r[1];
  assign dc_brake_level        = regs_r[2];
  assign dc_brake_time         = regs_r[3];
  assign start_freq            = regs_r[4];
  assign start_freq_hold_time  = regs_r[5];
  assign stop_freq             = regs_r[6];
  assign carrier_freq          = regs_r[7];
  assign stop_freq_hold_time   = regs_r[8];
  assign arrival_hysteresis    = regs_r[23];
  assign detect_level          = regs_r[24];
  assign detect_hysteresis     = regs_r[25];
  assign speed_display_coeff   = regs_r[26];
  assign brake_release_current = regs_r[27];
  assign brake_release_freq    = regs_r[28];
  assign brake_release_timer   = regs_r[29];
  assign freq_limit_high       = regs_r[30];
  assign terminal_functions    = {regs_r[22], regs_r[21], regs_r[20], regs_r[19],
                                  regs_r[18], regs_r[17], regs_r[16]};

endmodule // dprb_bank
`default_nettype wire

/* rtl/dprb_map.vh */
`ifndef DPRB_MAP_VH
`define DPRB_MAP_VH
// register word addresses
`define DPRB_A_FLIM_LOW     16'h000e
`define DPRB_A_DCB_FREQ     16'h000f
`define DPRB_A_DCB_LEVEL    16'h0010
`define DPRB_A_DCB_TIME     16'h0011
`define DPRB_A_START_FREQ   16'h0012
`define DPRB_A_START_HOLD   16'h0013
`define DPRB_A_STOP_FREQ    16'h0014
`define DPRB_A_CARRIER      16'h0015
`define DPRB_A_STOP_HOLD    16'h0017
`define DPRB_A_CTRL_STRAT   16'h0018
`define DPRB_A_CLIM_MODE    16'h0019
`define DPRB_A_CLIM_LEVEL   16'h001a
`define DPRB_A_BR_DUTY      16'h001c
`define DPRB_A_DIG_FREF     16'h001d
`define DPRB_A_TQ_BOOST     16'h001e
`define DPRB_A_DYN_BRAKE    16'h001f
`define DPRB_A_IN1_FUNC     16'h0101
`define DPRB_A_IN2_FUNC     16'h0102
`define DPRB_A_IN3_FUNC     16'h0103
`define DPRB_A_IN4_FUNC     16'h0104
`define DPRB_A_IN5_FUNC     16'h0105
`define DPRB_A_TOUT_FUNC    16'h0106
`define DPRB_A_ROUT_FUNC    16'h0107
`define DPRB_A_ARR_HYST     16'h010a
`define DPRB_A_DET_LEVEL    16'h010b
`define DPRB_A_DET_HYST     16'h010c
`define DPRB_A_SPD_COEFF    16'h010d
`define DPRB_A_BRK_CUR      16'h010e
`define DPRB_A_BRK_FREQ     16'h010f
`define DPRB_A_BRK_TIMER    16'h0110
`define DPRB_A_FLIM_HIGH    16'h000d
// reset values
`define DPRB_R_FLIM_LOW     16'h0000
`define DPRB_R_DCB_FREQ     16'h0000
`define DPRB_R_DCB_LEVEL    16'h0000
`define DPRB_R_DCB_TIME     16'h0000
`define DPRB_R_START_FREQ   16'h000a
`define DPRB_R_START_HOLD   16'h0000
`define DPRB_R_STOP_FREQ    16'h0002
`define DPRB_R_CARRIER      16'h0004
`define DPRB_R_STOP_HOLD    16'h0000
`define DPRB_R_CTRL_STRAT   16'h0001
`define DPRB_R_CLIM_MODE    16'h0002
`define DPRB_R_CLIM_LEVEL   16'h00b4
`define DPRB_R_BR_DUTY      16'h0064
`define DPRB_R_DIG_FREF     16'h0000
`define DPRB_R_TQ_BOOST     16'h0032
`define DPRB_R_DYN_BRAKE    16'h0002
`define DPRB_R_IN1_FUNC     16'h0062
`define DPRB_R_IN2_FUNC     16'h0061
`define DPRB_R_IN3_FUNC     16'h0000
`define DPRB_R_IN4_FUNC     16'h0028
`define DPRB_R_IN5_FUNC     16'h0008
`define DPRB_R_TOUT_FUNC    16'h0039
`define DPRB_R_ROUT_FUNC    16'h0063
`define DPRB_R_ARR_HYST     16'h0019
`define DPRB_R_DET_LEVEL    16'h0258
`define DPRB_R_DET_HYST     16'h000a
`define DPRB_R_SPD_COEFF    16'h0bb8
`define DPRB_R_BRK_CUR      16'h0064
`define DPRB_R_BRK_FREQ     16'h000a
`define DPRB_R_BRK_TIMER    16'h000a
`define DPRB_R_FLIM_HIGH    16'h03e8
// ranges (min, max) in register units; refused input function codes last
`define DPRB_MAX_FREQ120    16'h04b0
`define DPRB_MAX_FREQ60     16'h0258
`define DPRB_MAX_PCT100     16'h0064
`define DPRB_MAX_PCT200     16'h00c8
`define DPRB_MIN_PCT20      16'h0014
`define DPRB_MAX_DCB_TIME   16'h0bb8
`define DPRB_MAX_HOLD       16'h03e8
`define DPRB_MIN_FREQ01     16'h0001
`define DPRB_MIN_CARRIER    16'h0002
`define DPRB_MAX_CARRIER    16'h000a
`define DPRB_MAX_MODE2      16'h0002
`define DPRB_MIN_DUTY       16'h0001
`define DPRB_MAX_DUTY       16'h01f4
`define DPRB_MAX_FREF       16'h2ee0
`define DPRB_MAX_BOOST      16'h00c8
`define DPRB_MAX_ARR_HYST   16'h0064
`define DPRB_MIN_COEFF      16'h0001
`define DPRB_MAX_COEFF      16'h4e20
`define DPRB_MAX_FREQ25     16'h00fa
`define DPRB_MAX_TIMER5     16'h0032
`define DPRB_FUNC_INV_FWD   16'h044a
`define DPRB_FUNC_INV_REV   16'h044b
// decoded modes
`define DPRB_CS_VF_NOSLIP   2'h0
`define DPRB_CS_TORQUE_VEC  2'h1
`define DPRB_CS_VF_SLIP     2'h2
`endif

/* sim/dprb_assertions.sv */
`include "dprb_map.vh"
`timescale 1ns/100ps
`default_nettype none
module dprb_assertions (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        wr_en,
  input wire logic        rd_en,
  input wire logic [15:0] addr,
  input wire logic [15:0] wdata,
  input wire logic        ack,
  input wire logic        nack,
  input wire logic        run_state,
  input wire logic        ramping_phase,
  input wire logic [1:0]  control_strategy,
  input wire logic        current_limit_active,
  input wire logic [15:0] current_limit_level,
  input wire logic        dynamic_brake_active,
  input wire logic        dc_brake_enable,
  input wire logic [15:0] dc_brake_time,
  input wire logic [15:0] carrier_freq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_req;
    wr_en || rd_en;
  endsequence
  sequence s_answer;
    ack ^ nack;
  endsequence
  sequence s_car_wr;
    wr_en && addr == `DPRB_A_CARRIER;
  endsequence
  one_answer_a: assert property (s_req |=> s_answer) else $error("request not answered once");
  idle_silent_a: assert property (!(wr_en || rd_en) |=> !ack && !nack) else $error("answer without request");
  carrier_write_a: assert property (s_car_wr ##0 (wdata >= 16'h0002 && wdata <= 16'h000a)
    |=> ack && carrier_freq == $past(wdata)) else $error("carrier write lost");
  carrier_refuse_a: assert property (s_car_wr ##0 (wdata < 16'h0002 || wdata > 16'h000a)
    |=> nack && $stable(carrier_freq)) else $error("carrier bad write taken");
  level_range_a: assert property (current_limit_level >= 16'h0014 && current_limit_level <= 16'h00c8)
    else $error("limiter level out of range");
  limit_off_a: assert property (wr_en && addr == `DPRB_A_CLIM_MODE && wdata == 16'h0000
    |=> !current_limit_active) else $error("limiter active in mode 0");
  limit_const_a: assert property (wr_en && addr == `DPRB_A_CLIM_MODE && wdata == 16'h0001
    |=> current_limit_active == (run_state && !ramping_phase)) else $error("limiter mode 1 wrong");
  dyn_both_a: assert property (wr_en && addr == `DPRB_A_DYN_BRAKE && wdata == 16'h0002
    |=> dynamic_brake_active) else $error("dynamic braking off in mode 2");
  dc_enable_a: assert property (dc_brake_enable == (dc_brake_time != 16'h0000))
    else $error("dc braking enable wrong");
  strat_range_a: assert property (control_strategy != 2'h3) else $error("bad control strategy");
  reset_default_a: assert property ($rose(rst_n) |-> carrier_freq == 16'h0004 && current_limit_level == 16'h00b4)
    else $error("defaults not loaded");
endmodule // dprb_assertions
bind dprb_bank dprb_assertions u_chk (.clk, .rst_n, .wr_en, .rd_en, .addr, .wdata, .ack, .nack, .run_state,
  .ramping_phase, .control_strategy, .current_limit_active, .current_limit_level, .dynamic_brake_active,
  .dc_brake_enable, .dc_brake_time, .carrier_freq);
`default_nettype wire

/* sim/dprb_master.sv */
`timescale 1ns/100ps
`default_nettype none
module dprb_master (
  input  wire logic        clk,
  input  wire logic        ack,
  input  wire logic        nack,
  input  wire logic [15:0] rdata,
  output logic             wr_en,
  output logic             rd_en,
  output logic [15:0]      addr,
  output logic [15:0]      wdata
);
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr  = 16'h0000;
    wdata = 16'h0000;
  end
  // inverted run codes leave here only when a test wants a refusal
  task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
                      output logic [15:0] q, output logic [1:0] r);
    @(negedge clk);
    wr_en = w;
    rd_en = !w;
    addr  = a;
    wdata = d;
    @(negedge clk);
    r = {nack, ack};
    q = rdata;
    wr_en = 1'b0;
    rd_en = 1'b0;
    // released lines show the inverse so a stale value cannot pass
    addr  = ~a;
    wdata = ~d;
  endtask
endmodule // dprb_master
`default_nettype wire

/* sim/tb.sv */
`include "dprb_map.vh"
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fail_count++; $display("wrong value %s exp %h got %h", n, e, g); end end
module tb;
  logic        clk;
  logic        rst_n;
  logic        run_state;
  logic        ramping_phase;
  wire         wr_en, rd_en, ack, nack, cla, dba, dbe;
  wire [111:0] tf;
  wire  [15:0] addr, wdata, rdata;
  wire  [1:0]  cs;
  int          fail_count, check_count, cycles;
  logic [15:0] q;
  logic [1:0]  r;
  logic [15:0] mdl [logic [15:0]];
  logic [15:0] ra [19] = '{`DPRB_A_CARRIER, `DPRB_A_CLIM_LEVEL, `DPRB_A_START_FREQ, `DPRB_A_DCB_FREQ,
    `DPRB_A_DCB_LEVEL, `DPRB_A_BRK_TIMER, `DPRB_A_BRK_FREQ, `DPRB_A_BRK_CUR, `DPRB_A_ARR_HYST, `DPRB_A_DET_HYST,
    `DPRB_A_IN1_FUNC, `DPRB_A_CTRL_STRAT, `DPRB_A_DCB_TIME, `DPRB_A_CLIM_MODE, `DPRB_A_DYN_BRAKE,
    `DPRB_A_STOP_FREQ, `DPRB_A_DET_LEVEL, `DPRB_A_SPD_COEFF, `DPRB_A_FLIM_HIGH};
  logic [15:0] rv [19] = '{16'h0004, 16'h00b4, 16'h000a, 16'h0000, 16'h0000, 16'h000a, 16'h000a, 16'h0064,
    16'h0019, 16'h000a, 16'h0062, 16'h0001, 16'h0000, 16'h0002, 16'h0002, 16'h0002, 16'h0258, 16'h0bb8, 16'h03e8};
  logic [15:0] ba [27] = '{`DPRB_A_CARRIER, `DPRB_A_CARRIER, `DPRB_A_CARRIER, `DPRB_A_CARRIER,
    `DPRB_A_CLIM_LEVEL, `DPRB_A_CLIM_LEVEL, `DPRB_A_CLIM_LEVEL, `DPRB_A_START_FREQ, `DPRB_A_START_FREQ,
    `DPRB_A_DCB_FREQ, `DPRB_A_DCB_FREQ, `DPRB_A_DCB_LEVEL, `DPRB_A_BRK_TIMER, `DPRB_A_BRK_TIMER,
    `DPRB_A_BRK_FREQ, `DPRB_A_BRK_CUR, `DPRB_A_ARR_HYST, `DPRB_A_DET_HYST, `DPRB_A_IN1_FUNC, `DPRB_A_IN1_FUNC,
    `DPRB_A_CTRL_STRAT, `DPRB_A_DCB_TIME, `DPRB_A_SPD_COEFF, `DPRB_A_FLIM_HIGH, `DPRB_A_FLIM_HIGH,
    `DPRB_A_STOP_FREQ, `DPRB_A_DET_LEVEL};
  logic [15:0] bv [27] = '{16'h0001, 16'h0002, 16'h000b, 16'h000a, 16'h0013, 16'h00c9, 16'h0014, 16'h0000,
    16'h0258, 16'h0259, 16'h0258, 16'h0065, 16'h0033, 16'h0032, 16'h00fb, 16'h00c9, 16'h0065, 16'h04b1,
    16'h044a, 16'h044b, 16'h0003, 16'h0bb9, 16'h0000, 16'h04b1, 16'h04b0, 16'h0000, 16'h04b1};
  logic        bk [27] = '{0, 1, 0, 1, 0, 0, 1, 0, 1, 0, 1, 0, 0, 1, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 1, 0, 0};

  dprb_bank DUT (.clk(clk), .rst_n(rst_n), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata),
    .rdata(rdata), .ack(ack), .nack(nack), .run_state(run_state), .ramping_phase(ramping_phase),
    .control_strategy(cs), .current_limit_active(cla), .current_limit_level(), .dynamic_brake_active(dba),
    .dc_brake_enable(dbe), .dc_brake_level(), .dc_brake_start_freq(), .dc_brake_time(), .start_freq(),
    .start_freq_hold_time(), .stop_freq(), .stop_freq_hold_time(), .carrier_freq(), .freq_limit_low(),
    .freq_limit_high(), .arrival_hysteresis(), .detect_level(), .detect_hysteresis(), .speed_display_coeff(),
    .brake_release_current(), .brake_release_freq(), .brake_release_timer(), .terminal_functions(tf));
  dprb_master m (.clk(clk), .ack(ack), .nack(nack), .rdata(rdata), .wr_en(wr_en), .rd_en(rd_en),
    .addr(addr), .wdata(wdata));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ceiling well above the few hundred cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      finish_test;
    end
  end

  task finish_test;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task do_reset;
    rst_n = 1'b0;
    // count rising edges: the first falling event at time zero is a race
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
  endtask

  task rd_chk(input logic [15:0] a, input logic [15:0] e);
    m.xfer(1'b0, a, 16'h0000, q, r);
    `CHK("read answer", 2'b01, r)
    `CHK("rdata", e, q)
  endtask

  task wr(input logic [15:0] a, input logic [15:0] d, input logic ok);
    m.xfer(1'b1, a, d, q, r);
    `CHK("write answer", ok ? 2'b01 : 2'b10, r)
    if (ok)
      mdl[a] = d;
  endtask

  initial begin
    run_state = 1'b0;
    ramping_phase = 1'b0;
    do_reset;
    foreach (ra[i]) mdl[ra[i]] = rv[i];
    foreach (ra[i]) rd_chk(ra[i], rv[i]);
    `CHK("input one function", 16'h0062, tf[15:0])
    `CHK("relay function", 16'h0063, tf[111:96])
    `CHK("dc enable at reset", 1'b0, dbe)
    $display("test reset values done");
    foreach (ba[i]) begin
      wr(ba[i], bv[i], bk[i]);
      rd_chk(ba[i], mdl[ba[i]]);
    end
    m.xfer(1'b0, 16'h0016, 16'h0000, q, r);
    `CHK("unmapped answer", 2'b10, r)
    `CHK("unmapped rdata", 16'h0000, q)
    $display("test range limits done");
    for (int mo = 0; mo < 3; mo++) begin
      wr(`DPRB_A_CLIM_MODE, 16'(mo), 1'b1);
      wr(`DPRB_A_DYN_BRAKE, 16'(mo), 1'b1);
      wr(`DPRB_A_CTRL_STRAT, 16'(mo), 1'b1);
      `CHK("strategy", 2'(mo), cs)
      for (int s = 0; s < 4; s++) begin
        @(negedge clk);
        {run_state, ramping_phase} = 2'(s);
        #1;
        `CHK("limiter", mo == 2 || (mo == 1 && s == 2), cla)
        `CHK("dyn brake", mo == 2 || (mo == 1 && run_state), dba)
      end
    end
    wr(`DPRB_A_DCB_TIME, 16'h0bb8, 1'b1);
    `CHK("dc enable on", 1'b1, dbe)
    rd_chk(`DPRB_A_DCB_TIME, 16'h0bb8);
    wr(`DPRB_A_DCB_TIME, 16'h0000, 1'b1);
    `CHK("dc enable off", 1'b0, dbe)
    $display("test modes done");
    wr(`DPRB_A_CARRIER, 16'h0007, 1'b1);
    do_reset;
    rd_chk(`DPRB_A_CARRIER, 16'h0004);
    rd_chk(`DPRB_A_CLIM_MODE, 16'h0002);
    $display("test second reset done");
    finish_test;
  end
endmodule // tb
`default_nettype wire
